//--- src/chi_pkg.sv
// Shared constants and types for the charger I2C host controller.
package chi_pkg;

   // Fixed 7-bit target address and the direction bit values.
   localparam logic [6:0] TARGET_ADDR = 7'h6B;
   localparam logic       DIR_WRITE   = 1'h0;
   localparam logic       DIR_READ    = 1'h1;

   // Highest register command address the host passes on to the target.
   localparam logic [7:0] REG_LAST = 8'h3F;

   // Bit slot of the acknowledge within a byte, and quarter indices.
   localparam logic [3:0] ACK_BIT_IDX = 4'h8;
   localparam logic [1:0] Q_FIRST     = 2'h0;
   localparam logic [1:0] Q_SDA_SET   = 2'h1;
   localparam logic [1:0] Q_SCL_REL   = 2'h2;
   localparam logic [1:0] Q_LAST      = 2'h3;

   // Clock period and the serial clock periods of both speed modes.
   localparam int CLK_PERIOD_NS      = 40;
   localparam int STD_SCL_PERIOD_NS  = 10000;
   localparam int FAST_SCL_PERIOD_NS = 2500;

   // Cycles per quarter bit, rounded up so the rate never exceeds the limit.
   localparam int STD_QTR_CYC  =
      (STD_SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam int FAST_QTR_CYC =
      (FAST_SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

   // One register transaction request from the user side.
   typedef struct packed {
      logic       rd;
      logic [7:0] regAddr;
      logic [7:0] len;
   } chi_cmd_t;

   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} chi_state_t;

   typedef enum logic [2:0] {
      SG_AW, SG_REG, SG_AR, SG_WD, SG_RD
   } chi_stage_t;

endpackage : chi_pkg

//--- src/chi_i2c_host.sv
// I2C host controller that reads and writes the charger's registers.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Command byte, then data or repeated-start read.
// - Clock up to 100 or 400 kHz.
// - Both lines open drain, idle high.
// - Data changes only while clock is low.
// - Start and stop made with clock high.
// - Eight bits MSB first plus acknowledge.
// - Wait while target holds clock low.
// - Transmitter releases data on ninth pulse.
// - On not-acknowledge, issue stop.
// - First byte is address plus direction.
// - Paired setting: low byte, then high.
// - Host makes every clock pulse.
module chi_i2c_host #(
   parameter bit FAST_MODE = 1'b0
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire chi_pkg::chi_cmd_t cmd,
   input  wire logic             cmdValid,
   input  wire logic [7:0]       wrData,
   input  wire logic             wrValid,
   output logic                  wrTake,
   output logic [7:0]            rdData,
   output logic                  rdValid,
   output logic                  done,
   output logic                  err,
   output logic                  busy,
   input  wire logic             sclIn,
   output logic                  sclOut,
   output logic                  sclOeN,
   input  wire logic             sdaIn,
   output logic                  sdaOut,
   output logic                  sdaOeN
);

   localparam int         QTR_CYC  =
      FAST_MODE ? chi_pkg::FAST_QTR_CYC : chi_pkg::STD_QTR_CYC;
   localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

   chi_pkg::chi_state_t stQ, stD;
   chi_pkg::chi_stage_t stageQ;
   logic [1:0] qQ, qD;
   logic [7:0] qCntQ;
   logic [3:0] bitIdxQ;
   logic [7:0] shRegQ, rxRegQ, regAddrQ, remLenQ;
   logic       isReadQ;
   logic       sclMetaQ, sclSyncQ, sdaMetaQ, sdaSyncQ;
   logic       wrTakeQ, rdValidQ, doneQ, errQ, busyQ;
   logic [7:0] rdDataQ;
   logic       sclOeNQ, sdaOeNQ, sclOutQ, sdaOutQ;
   logic       sclRelD, sdaRelD;

   // Both bus lines pass two flops before anything looks at them.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sclMetaQ <= 1'h1;
         sclSyncQ <= 1'h1;
         sdaMetaQ <= 1'h1;
         sdaSyncQ <= 1'h1;
      end else begin
         sclMetaQ <= sclIn;
         sclSyncQ <= sclMetaQ;
         sdaMetaQ <= sdaIn;
         sdaSyncQ <= sdaMetaQ;
      end
   end

   // Quarter timing, stretch detection and byte-level decodes.
   wire logic       tick     = qCntQ == QTR_LAST;
   wire logic       stretch  = qQ == chi_pkg::Q_SCL_REL && !sclSyncQ;
   wire logic       rxMode   = stageQ == chi_pkg::SG_RD;
   wire logic       wrSlot   = stQ == chi_pkg::ST_BIT &&
                               stageQ == chi_pkg::SG_WD &&
                               bitIdxQ == 4'h0 && qQ == chi_pkg::Q_FIRST;
   wire logic       waitWr   = wrSlot && !wrValid;
   wire logic       adv      = stQ != chi_pkg::ST_IDLE && tick &&
                               !stretch && !waitWr;
   wire logic       bitEnd   = adv && stQ == chi_pkg::ST_BIT &&
                               qQ == chi_pkg::Q_LAST;
   wire logic       byteEnd  = bitEnd && bitIdxQ == chi_pkg::ACK_BIT_IDX;
   wire logic       nackSeen = byteEnd && !rxMode && sdaSyncQ;
   wire logic       lastByte = remLenQ == 8'h01;
   wire logic       dataEnd  = byteEnd && lastByte &&
                               (stageQ == chi_pkg::SG_WD || rxMode);
   wire logic       cmdOk    = cmd.regAddr <= chi_pkg::REG_LAST &&
                               cmd.len != 8'h00;
   wire logic       cmdTake  = stQ == chi_pkg::ST_IDLE && cmdValid;
   wire logic       stopEnd  = adv && stQ == chi_pkg::ST_STOP &&
                               qQ == chi_pkg::Q_LAST;
   wire logic [7:0] curByte  = wrSlot ? wrData : shRegQ;
   wire logic       dataBit  = curByte[3'h7 - bitIdxQ[2:0]];
   // Host acknowledges every read byte but the last, which ends the read.
   wire logic       ackDrive = rxMode && !lastByte;
   wire logic       bitRel   = (bitIdxQ == chi_pkg::ACK_BIT_IDX) ?
                               !ackDrive : (rxMode || dataBit);

   // Next state and quarter; a stretch or a missing write byte freezes it.
   always_comb begin
      stD = stQ;
      qD  = qQ;
      if (cmdTake && cmdOk) begin
         // Both lines already high, so the start begins at its high phase.
         stD = chi_pkg::ST_START;
         qD  = chi_pkg::Q_SCL_REL;
      end else if (adv) begin
         if (qQ != chi_pkg::Q_LAST) begin
            qD = qQ + 2'h1;
         end else begin
            qD = chi_pkg::Q_FIRST;
            unique case (stQ)
               chi_pkg::ST_START: stD = chi_pkg::ST_BIT;
               chi_pkg::ST_STOP:  stD = chi_pkg::ST_IDLE;
               chi_pkg::ST_BIT: begin
                  if (byteEnd) begin
                     if (nackSeen || dataEnd) begin
                        stD = chi_pkg::ST_STOP;
                     end else if (stageQ == chi_pkg::SG_REG && isReadQ) begin
                        stD = chi_pkg::ST_START;
                     end
                  end
               end
               chi_pkg::ST_IDLE:  stD = chi_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // Line levels for the coming quarter; quarter zero keeps data unchanged.
   always_comb begin
      sclRelD = stD == chi_pkg::ST_IDLE || qD >= chi_pkg::Q_SCL_REL;
      unique case (stD)
         chi_pkg::ST_IDLE:  sdaRelD = 1'h1;
         chi_pkg::ST_START: sdaRelD = (qD == chi_pkg::Q_FIRST) ? sdaOeNQ :
                                      qD != chi_pkg::Q_LAST;
         chi_pkg::ST_STOP:  sdaRelD = (qD == chi_pkg::Q_FIRST) ? sdaOeNQ :
                                      qD == chi_pkg::Q_LAST;
         chi_pkg::ST_BIT:   sdaRelD = (qD == chi_pkg::Q_FIRST) ? sdaOeNQ :
                                      bitRel;
      endcase
   end

   // State, quarter counter and open-drain drive; low enable pulls low.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stQ     <= chi_pkg::ST_IDLE;
         qQ      <= chi_pkg::Q_FIRST;
         qCntQ   <= 8'h00;
         sclOeNQ <= 1'h1;
         sdaOeNQ <= 1'h1;
         sclOutQ <= 1'h0;
         sdaOutQ <= 1'h0;
      end else begin
         stQ     <= stD;
         qQ      <= qD;
         qCntQ   <= (stQ == chi_pkg::ST_IDLE || adv) ? 8'h00 :
                    (tick ? qCntQ : qCntQ + 8'h01);
         sclOeNQ <= sclRelD;
         sdaOeNQ <= sdaRelD;
         sclOutQ <= 1'h0;
         sdaOutQ <= 1'h0;
      end
   end

   // Bit counter and received-byte shifter.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bitIdxQ <= 4'h0;
         rxRegQ  <= 8'h00;
      end else begin
         if (cmdTake || byteEnd) begin
            bitIdxQ <= 4'h0;
         end else if (bitEnd) begin
            bitIdxQ <= bitIdxQ + 4'h1;
         end
         if (bitEnd && !byteEnd && rxMode) begin
            rxRegQ <= {rxRegQ[6:0], sdaSyncQ};
         end
      end
   end

   // Byte sequencing through address, command, address again and data.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stageQ   <= chi_pkg::SG_AW;
         shRegQ   <= 8'h00;
         regAddrQ <= 8'h00;
         remLenQ  <= 8'h00;
         isReadQ  <= 1'h0;
      end else if (cmdTake && cmdOk) begin
         stageQ   <= chi_pkg::SG_AW;
         shRegQ   <= {chi_pkg::TARGET_ADDR, chi_pkg::DIR_WRITE};
         regAddrQ <= cmd.regAddr;
         remLenQ  <= cmd.len;
         isReadQ  <= cmd.rd;
      end else if (adv && wrSlot) begin
         shRegQ <= wrData;
      end else if (byteEnd && !nackSeen) begin
         unique case (stageQ)
            chi_pkg::SG_AW: begin
               stageQ <= chi_pkg::SG_REG;
               shRegQ <= regAddrQ;
            end
            chi_pkg::SG_REG: begin
               if (isReadQ) begin
                  stageQ <= chi_pkg::SG_AR;
                  shRegQ <= {chi_pkg::TARGET_ADDR, chi_pkg::DIR_READ};
               end else begin
                  stageQ <= chi_pkg::SG_WD;
               end
            end
            chi_pkg::SG_AR: stageQ <= chi_pkg::SG_RD;
            chi_pkg::SG_WD, chi_pkg::SG_RD: remLenQ <= remLenQ - 8'h01;
         endcase
      end
   end

   // User-side pulses and status; the error stands until the next command.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wrTakeQ  <= 1'h0;
         rdValidQ <= 1'h0;
         rdDataQ  <= 8'h00;
         doneQ    <= 1'h0;
         errQ     <= 1'h0;
         busyQ    <= 1'h0;
      end else begin
         wrTakeQ  <= adv && wrSlot;
         rdValidQ <= byteEnd && rxMode;
         if (byteEnd && rxMode) begin
            rdDataQ <= rxRegQ;
         end
         doneQ    <= stopEnd || (cmdTake && !cmdOk);
         errQ     <= (nackSeen || (cmdTake && !cmdOk)) ? 1'h1 :
                     (cmdTake ? 1'h0 : errQ);
         busyQ    <= stD != chi_pkg::ST_IDLE;
      end
   end

   assign wrTake  = wrTakeQ;
   assign rdValid = rdValidQ;
   assign rdData  = rdDataQ;
   assign done    = doneQ;
   assign err     = errQ;
   assign busy    = busyQ;
   assign sclOeN  = sclOeNQ;
   assign sdaOeN  = sdaOeNQ;
   assign sclOut  = sclOutQ;
   assign sdaOut  = sdaOutQ;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Guards on the bus waveform the host produces.
   AST_DATA_CLK_LOW: assert property (
      (stQ == chi_pkg::ST_BIT && $changed(sdaOeNQ)) |->
         (!sclOeNQ && $past(!sclOeNQ))
   ) else $error("data line moved while clock was released");
   AST_IDLE_RELEASED: assert property (
      (stQ == chi_pkg::ST_IDLE && $past(stQ) == chi_pkg::ST_IDLE) |->
         (sclOeNQ && sdaOeNQ)
   ) else $error("a line is pulled low while idle");
   AST_START_ONLY: assert property (
      ($fell(sdaOeNQ) && sclOeNQ) |-> stQ == chi_pkg::ST_START
   ) else $error("data fell with clock high outside a start");
   AST_STOP_ONLY: assert property (
      ($rose(sdaOeNQ) && sclOeNQ) |-> $past(stQ) == chi_pkg::ST_STOP
   ) else $error("data rose with clock high outside a stop");
   AST_STRETCH_WAIT: assert property (
      (stQ != chi_pkg::ST_IDLE && qQ == chi_pkg::Q_SCL_REL && !sclSyncQ)
         |=> (qQ == chi_pkg::Q_SCL_REL && sclOeNQ)
   ) else $error("clock advanced while target held it low");
   AST_ACK_RELEASE: assert property (
      (stQ == chi_pkg::ST_BIT && bitIdxQ == chi_pkg::ACK_BIT_IDX &&
       qQ != chi_pkg::Q_FIRST && !rxMode) |-> sdaOeNQ
   ) else $error("host drove data during a target acknowledge");
   AST_NACK_STOP: assert property (
      nackSeen |=> (stQ == chi_pkg::ST_STOP && errQ) ##1
         (stQ == chi_pkg::ST_STOP) [*3]
   ) else $error("no stop after not-acknowledge");
   AST_ADDR_FIRST: assert property (
      (stQ == chi_pkg::ST_BIT && stageQ == chi_pkg::SG_AW) |->
         shRegQ == {chi_pkg::TARGET_ADDR, chi_pkg::DIR_WRITE}
   ) else $error("first byte is not the write address");
   AST_BIT_RANGE: assert property (
      bitEnd |-> bitIdxQ <= chi_pkg::ACK_BIT_IDX
   ) else $error("more than nine slots in a byte");
   // A held write byte parks the count at its end, so that quarter is longer.
   AST_QTR_LEN: assert property (
      (adv && qQ == chi_pkg::Q_FIRST) |->
         ($past(qCntQ) == QTR_LAST - 8'h01 || $past(waitWr))
   ) else $error("quarter shorter than the rate allows");

   COV_WRITE_DONE: cover property (doneQ && !errQ && !isReadQ);
   COV_READ_DONE:  cover property (doneQ && !errQ && isReadQ);
   COV_NACK:       cover property (nackSeen);
   COV_STRETCH:    cover property (stretch [*3]);

endmodule : chi_i2c_host

`default_nettype wire

//--- bench/chi_tgt_model.sv
// Behavioural charger target that answers the host on the two wires.
`timescale 1ns/1ns
`default_nettype none
module chi_tgt_model #(
   parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value.
   parameter logic [7:0] PART_ID  = 8'hC1, // Arbitrary value.
   parameter int         WDOG_NS  = 100000
) (
   input  wire logic        scl,
   input  wire logic        sda,
   input  wire logic [15:0] stretchNs,
   output logic             sclHoldN,
   output logic             sdaHoldN,
   output logic [7:0]       startCnt,
   output logic [7:0]       stopCnt
);
   typedef enum logic [2:0] {M_IDLE, M_ADDR, M_REG, M_WR, M_RD} chi_mst_t;
   chi_mst_t   st;
   logic [7:0] regs [0:63];
   logic [7:0] sh, rdByte, ptr, pendLo, pendAt;
   logic [3:0] bitCnt;
   logic       inAck, pendOk, hostAck;
   time        pendT;

   initial begin
      for (int i = 0; i < 64; i++) begin
         regs[i] = 8'h00;
      end
      regs[6'h2E] = MAKER_ID;
      regs[6'h2F] = PART_ID;
      {sclHoldN, sdaHoldN, pendOk, inAck} = 4'hC;
      {startCnt, stopCnt, st} = '0;
   end

   // Holes in the map are refused, so a stray address shows up as a NACK.
   function automatic logic known(input logic [7:0] a);
      return (a <= 8'h0F) || (a >= 8'h20 && a <= 8'h3D);
   endfunction : known

   function automatic logic pairLow(input logic [7:0] a);
      return a == 8'h02 || a == 8'h04 || a == 8'h06 || a == 8'h0A
         || a == 8'h24;
   endfunction : pairLow

   task automatic store(input logic [7:0] a, input logic [7:0] d);
      if (pairLow(a)) begin
         {pendLo, pendAt, pendOk} = {d, a, 1'b1};
         pendT = $time;
      end else if (pairLow(a - 8'h01)) begin
         if (pendOk && pendAt == a - 8'h01 && $time - pendT <= WDOG_NS) begin
            regs[pendAt[5:0]] = pendLo;
            regs[a[5:0]] = d;
         end
         pendOk = 1'b0;
      end else begin
         if (a != 8'h2E && a != 8'h2F) regs[a[5:0]] = d;
         pendOk = 1'b0;
      end
   endtask : store

   task automatic take_byte;
      logic ok;
      ok = 1'b1;
      case (st)
         M_ADDR: begin
            ok = (sh[7:1] == 7'h6B);
            st = sh[0] ? M_RD : M_REG;
            rdByte = regs[ptr[5:0]];
         end
         M_REG: begin
            ok = known(sh);
            ptr = sh;
            st = M_WR;
         end
         default: begin
            store(ptr, sh);
            ptr = ptr + 8'h01;
         end
      endcase
      sdaHoldN = !ok;
      if (!ok) st = M_IDLE;
   endtask : take_byte

   // start and stop seen only on a settled high clock.
   always @(negedge sda) if (scl === 1'b1) begin
      {st, bitCnt, inAck} = {M_ADDR, 4'h0, 1'b0};
      startCnt++;
   end
   always @(posedge sda) if (scl === 1'b1) begin
      st = M_IDLE;
      stopCnt++;
   end

   // sample on the rising clock, MSB first.
   always @(posedge scl) if (st != M_IDLE) begin
      if (!inAck) begin
         sh = {sh[6:0], sda};
         bitCnt++;
      end else if (st == M_RD && hostAck) begin
         if (sda) st = M_IDLE;
         else ptr = ptr + 8'h01;
         rdByte = regs[ptr[5:0]];
      end
   end

   // drive on the falling clock, stretch after each byte.
   always @(negedge scl) if (st != M_IDLE) begin
      if (inAck) begin
         {inAck, bitCnt, sdaHoldN} = {1'b0, 4'h0, 1'b1};
      end else if (bitCnt == 4'h8) begin
         inAck = 1'b1;
         // In a read, only the host's answer to a sent byte moves the pointer on.
         hostAck = (st == M_RD);
         if (st == M_RD) sdaHoldN = 1'b1;
         else take_byte();
      end
      if (st == M_RD && !inAck) sdaHoldN = rdByte[3'h7 - bitCnt[2:0]];
      if (bitCnt == 4'h0 && !inAck && stretchNs != 16'h0) begin
         sclHoldN = 1'b0;
         #(stretchNs) sclHoldN = 1'b1;
      end
   end
endmodule : chi_tgt_model
`default_nettype wire

//--- bench/test_chi_i2c_host.sv
// Self-checking bench for the charger I2C host controller.
`timescale 1ns/1ns
`default_nettype none
module test_chi_i2c_host;
   logic              clk = 1'b0, sysRst = 1'b1, cmdValid = 1'b0;
   chi_pkg::chi_cmd_t cmd = '0;
   logic [7:0]        wrData = 8'h00, rdData;
   logic              wrValid = 1'b0, wrTake, rdValid, done, err, busy;
   logic              sclOut, sclOeN, sdaOut, sdaOeN, tSclN, tSdaN;
   logic [15:0]       stretchNs = 16'h0;
   logic [7:0]        startCnt, stopCnt, s0, p0;
   logic [7:0]        wbuf [0:7], rbuf [0:7];
   logic              gotErr;
   int                cyc, takes, errCount = 0, nChecks = 0;
   wire logic         sclW = sclOeN & tSclN;
   wire logic         sdaW = sdaOeN & tSdaN;

   always #20 clk = ~clk;

   chi_i2c_host #(.FAST_MODE(1'b1)) uut (.clk(clk), .sys_rst(sysRst),
      .cmd(cmd), .cmdValid(cmdValid), .wrData(wrData), .wrValid(wrValid),
      .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid), .done(done),
      .err(err), .busy(busy), .sclIn(sclW), .sclOut(sclOut),
      .sclOeN(sclOeN), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOeN(sdaOeN));

   chi_tgt_model tgt (.scl(sclW), .sda(sdaW), .stretchNs(stretchNs),
      .sclHoldN(tSclN), .sdaHoldN(tSdaN), .startCnt(startCnt),
      .stopCnt(stopCnt));

   task automatic closeOut;
      $display("checks %0d mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : closeOut

   task automatic check(input logic ok, input string msg);
      nChecks++;
      if (ok !== 1'b1) begin
         errCount++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : check

   // One whole transfer; a stall holds back the first write byte.
   task automatic xfer(input logic rd, input logic [7:0] ra,
                       input logic [7:0] len, input int stall);
      int n, k, r;
      {n, k, r} = '0;
      s0 = startCnt;
      p0 = stopCnt;
      @(posedge clk);
      cmd <= '{rd, ra, len};
      cmdValid <= 1'b1;
      wrData <= wbuf[0];
      wrValid <= (stall == 0);
      @(posedge clk);
      cmdValid <= 1'b0;
      while (done !== 1'b1 && n < 20000) begin
         @(posedge clk);
         n++;
         if (n == stall) wrValid <= 1'b1;
         if (wrTake === 1'b1) k++;
         if (wrTake === 1'b1) wrData <= wbuf[k[2:0]];
         if (rdValid === 1'b1) rbuf[r[2:0]] = rdData;
         if (rdValid === 1'b1) r++;
      end
      {gotErr, cyc} = {err, n};
      takes = k;
      wrValid <= 1'b0;
      check(n < 20000, "transfer never finished");
   endtask : xfer

   task automatic t_refuse;
      xfer(1'b0, 8'h40, 8'h01, 0);
      check(gotErr === 1'b1 && cyc == 1, "high address not refused");
      xfer(1'b1, 8'h00, 8'h00, 0);
      check(gotErr === 1'b1 && startCnt === s0, "empty read used bus");
   endtask : t_refuse

   task automatic t_ident;
      xfer(1'b1, 8'h2E, 8'h02, 0);
      check(rbuf[0] === 8'h5A && rbuf[1] === 8'hC1, "identity wrong");
      check(startCnt === s0 + 8'h2 && stopCnt === p0 + 8'h1, "framing");
      check(gotErr === 1'b0, "identity read flagged");
   endtask : t_ident

   task automatic t_pair;
      wbuf[0] = 8'h34;
      wbuf[1] = 8'h12;
      // The stall outlasts the address and command bytes, so data waits.
      xfer(1'b0, 8'h04, 8'h02, 1500);
      check(takes == 2 && gotErr === 1'b0, "write bytes taken");
      xfer(1'b1, 8'h04, 8'h02, 0);
      check(rbuf[0] === 8'h34 && rbuf[1] === 8'h12, "pair lost");
      wbuf[0] = 8'h77;
      xfer(1'b0, 8'h05, 8'h01, 0);
      xfer(1'b1, 8'h04, 8'h02, 0);
      check(rbuf[1] === 8'h12, "lone high byte taken");
   endtask : t_pair

   task automatic t_nack;
      xfer(1'b0, 8'h10, 8'h01, 0);
      check(gotErr === 1'b1, "undefined register not flagged");
      check(stopCnt === p0 + 8'h1 && sdaW === 1'b1, "no stop on nack");
   endtask : t_nack

   task automatic t_stretch;
      stretchNs = 16'd20000;
      {wbuf[0], wbuf[1], wbuf[2]} = 24'hA55AC3;
      xfer(1'b0, 8'h30, 8'h03, 0);
      xfer(1'b1, 8'h30, 8'h03, 0);
      check(rbuf[0] === 8'hA5 && rbuf[2] === 8'hC3, "stretched burst");
      check(rbuf[1] === 8'h5A && gotErr === 1'b0, "burst middle");
      stretchNs = 16'h0;
   endtask : t_stretch

   task automatic t_wdog;
      wbuf[0] = 8'h11;
      xfer(1'b0, 8'h0A, 8'h01, 0);
      repeat (1500) @(posedge clk);
      wbuf[0] = 8'h22;
      xfer(1'b0, 8'h0B, 8'h01, 0);
      xfer(1'b1, 8'h0A, 8'h02, 0);
      check(rbuf[0] === 8'h00 && rbuf[1] === 8'h00, "late pair taken");
   endtask : t_wdog

   // Reset for eight cycles, then every scenario in turn.
   initial begin
      repeat (8) @(posedge clk);
      sysRst <= 1'b0;
      repeat (2) @(posedge clk);
      check(sclW === 1'b1 && sdaW === 1'b1 && busy === 1'b0, "idle bus");
      check(sclOut === 1'b0 && sdaOut === 1'b0, "drive level");
      t_refuse();
      t_ident();
      t_pair();
      t_nack();
      t_stretch();
      t_wdog();
      closeOut();
   end

   // The whole run needs about one and a half milliseconds.
   initial begin
      #2400000;
      errCount++;
      closeOut();
   end
endmodule : test_chi_i2c_host
`default_nettype wire
